/* hdl/mact_pkg.sv */
// Constants and types for the VLAN/MAC forwarding table
package mact_pkg;
   localparam int unsigned TABLE_DEPTH = 8192;
   localparam int unsigned PORT_COUNT  = 11;
   localparam int unsigned STATIC_MAX  = 64;
   localparam int unsigned CNT_W       = 7;
   localparam int unsigned KEY_W       = 60;
   localparam int unsigned AXI_AW      = 8;
   // One-second tick derived from the core clock
   localparam int unsigned CLK_NS      = 20;
   localparam int unsigned SEC_NS      = 1_000_000_000;
   localparam int unsigned SEC_CYCLES  = SEC_NS / CLK_NS;
   // Aging time in seconds
   localparam int unsigned AGE_W       = 24;
   localparam logic [31:0] AGE_MIN     = 32'h0000_000A;
   localparam logic [31:0] AGE_MAX     = 32'h0098_9680;
   localparam logic [23:0] AGE_RST     = 24'h00_012C;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_AGE      = 8'h04;
   localparam logic [7:0] OFS_MODE     = 8'h08;
   localparam logic [7:0] OFS_KVID     = 8'h0C;
   localparam logic [7:0] OFS_KMACLO   = 8'h10;
   localparam logic [7:0] OFS_KMACHI   = 8'h14;
   localparam logic [7:0] OFS_KPORTS   = 8'h18;
   localparam logic [7:0] OFS_CMD      = 8'h1C;
   localparam logic [7:0] OFS_STATUS   = 8'h20;
   localparam logic [7:0] OFS_RVID     = 8'h24;
   localparam logic [7:0] OFS_RMACLO   = 8'h28;
   localparam logic [7:0] OFS_RMACHI   = 8'h2C;
   localparam logic [7:0] OFS_RPORTS   = 8'h30;
   // Field positions
   localparam int unsigned CTRL_AGEOFF = 0;
   localparam int unsigned CTRL_FLUSH  = 1;
   localparam int unsigned CTRL_FIRST  = 2;
   localparam int unsigned CTRL_NEXT   = 3;
   localparam int unsigned CMD_ADD     = 0;
   localparam int unsigned CMD_DEL     = 1;
   localparam int unsigned ST_ERR      = 3;
   localparam logic [1:0] RESP_OKAY    = 2'b00;
   localparam logic [1:0] RESP_SLVERR  = 2'b10;
   typedef enum logic [1:0] {
      MODE_AUTO   = 2'b00,
      MODE_OFF    = 2'b01,
      MODE_SECURE = 2'b10
   } mact_mode_type;
   typedef enum logic [1:0] {
      WK_IDLE  = 2'b00,
      WK_SCAN  = 2'b01,
      WK_SWEEP = 2'b11,
      WK_FLUSH = 2'b10
   } mact_walk_type;
endpackage

/* hdl/mact_table.sv */
// VLAN/MAC forwarding table with learning, aging and readout
`timescale 1ns/1ps
module mact_table
   import mact_pkg::*;
#(
   parameter int unsigned DEPTH   = TABLE_DEPTH,
   parameter int unsigned NPORTS  = PORT_COUNT,
   parameter int unsigned SEC_CYC = SEC_CYCLES
)(
   // Clock and reset
   input  wire logic                   CORE_CLK_IN,
   input  wire logic                   RESET_IN,
   // Register bus
   input  wire logic [AXI_AW-1:0]      S_AXI_AWADDR_IN,
   input  wire logic                   S_AXI_AWVALID_IN,
   output logic                        S_AXI_AWREADY_OUT,
   input  wire logic [31:0]            S_AXI_WDATA_IN,
   input  wire logic [3:0]             S_AXI_WSTRB_IN,
   input  wire logic                   S_AXI_WVALID_IN,
   output logic                        S_AXI_WREADY_OUT,
   output logic [1:0]                  S_AXI_BRESP_OUT,
   output logic                        S_AXI_BVALID_OUT,
   input  wire logic                   S_AXI_BREADY_IN,
   input  wire logic [AXI_AW-1:0]      S_AXI_ARADDR_IN,
   input  wire logic                   S_AXI_ARVALID_IN,
   output logic                        S_AXI_ARREADY_OUT,
   output logic [31:0]                 S_AXI_RDATA_OUT,
   output logic [1:0]                  S_AXI_RRESP_OUT,
   output logic                        S_AXI_RVALID_OUT,
   input  wire logic                   S_AXI_RREADY_IN,
   // Frame lookup request
   input  wire logic                   LK_VALID_IN,
   input  wire logic [11:0]            LK_VID_IN,
   input  wire logic [47:0]            LK_DEST_HW_ADDR_IN,
   input  wire logic [47:0]            LK_SRC_HW_ADDR_IN,
   input  wire logic [$clog2(NPORTS)-1:0] LK_SRC_PORT_IN,
   input  wire logic [NPORTS-1:0]      LK_VLAN_PORTS_IN,
   // Frame lookup answer
   output logic                        LK_DONE_OUT,
   output logic [NPORTS-1:0]           LK_FWD_PORTS_OUT,
   output logic                        LK_DROP_OUT,
   output logic                        LK_HIT_OUT,
   // Ports whose mode another function owns
   input  wire logic [NPORTS-1:0]      MODE_LOCK_IN
);
   localparam int unsigned IW = $clog2(DEPTH);
   localparam int unsigned PW = $clog2(NPORTS);

   // Table storage
   logic [KEY_W-1:0]  key_mem [DEPTH];
   logic [NPORTS-1:0] port_mem [DEPTH];
   logic [DEPTH-1:0]  val_q;
   logic [DEPTH-1:0]  stat_q;
   logic [DEPTH-1:0]  act_q;

   // Registers
   logic                  ageoff_q;
   logic [AGE_W-1:0]      age_q;
   logic [2*NPORTS-1:0]   mode_q;
   logic [11:0]           kvid_q;
   logic [47:0]           kmac_q;
   logic [NPORTS-1:0]     kports_q;
   logic [KEY_W-1:0]      res_key_q;
   logic [NPORTS-1:0]     res_ports_q;
   logic                  res_stat_q;
   logic                  end_q;
   logic                  err_q;
   logic [CNT_W-1:0]      cnt_q;
   logic                  flush_p_q;
   logic                  first_p_q;
   logic                  next_p_q;
   logic                  add_p_q;
   logic                  del_p_q;

   // Bus slave state
   logic                  awready_q;
   logic                  wready_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  arready_q;
   logic                  rvalid_q;
   logic [1:0]            rresp_q;
   logic [31:0]           rdata_q;
   logic [AXI_AW-1:0]     awaddr_q;
   logic [31:0]           wdata_q;
   logic [3:0]            wstrb_q;

   // Walker and aging state
   mact_walk_type         walk_q;
   logic [IW-1:0]         widx_q;
   logic [KEY_W-1:0]      base_q;
   logic                  incl_q;
   logic                  found_q;
   logic [31:0]           sec_cnt_q;
   logic [AGE_W-1:0]      age_cnt_q;
   logic                  sweep_req_q;

   // Lookup answer
   logic                  done_q;
   logic [NPORTS-1:0]     fwd_q;
   logic                  drop_q;
   logic                  hit_q;

   function automatic logic [IW-1:0] hash_key(input logic [KEY_W-1:0] k);
      logic [IW-1:0] h;
      h = '0;
      for (int i = 0; i < KEY_W; i++)
         h[i % IW] = h[i % IW] ^ k[i];
      return h;
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
         if (s[b])
            r[8*b +: 8] = n[8*b +: 8];
      return r;
   endfunction

   // Lookup datapath
   logic [KEY_W-1:0]  dkey, skey, mkey, wkey;
   logic [IW-1:0]     di, si, mi;
   logic [NPORTS-1:0] src_one;
   logic [1:0]        pmode;
   logic              d_hit, s_hit, s_slot_stat, sec_fail, learn;
   logic              m_slot_stat, m_same, add_go, del_go;
   logic              take, wlast, busy, wr_fire;
   logic [31:0]       wm, wm0, rd_mux, wmode, wkvid, wkmhi, wkprt;
   logic              rd_ok, wr_ok;

   always_comb
   begin
      dkey = {LK_VID_IN, LK_DEST_HW_ADDR_IN};
      skey = {LK_VID_IN, LK_SRC_HW_ADDR_IN};
      mkey = {kvid_q, kmac_q};
      di = hash_key(dkey);
      si = hash_key(skey);
      mi = hash_key(mkey);
      src_one = '0;
      src_one[LK_SRC_PORT_IN] = 1'b1;
      pmode = mode_q[{LK_SRC_PORT_IN, 1'b0} +: 2];
      d_hit = val_q[di] && key_mem[di] == dkey;
      s_hit = val_q[si] && key_mem[si] == skey;
      s_slot_stat = val_q[si] && stat_q[si];
      sec_fail = pmode == MODE_SECURE && !(s_hit && stat_q[si]);
      // Only auto ports learn; a static slot is never overwritten
      learn = LK_VALID_IN && pmode == MODE_AUTO && !s_slot_stat;
      m_slot_stat = val_q[mi] && stat_q[mi];
      m_same = m_slot_stat && key_mem[mi] == mkey;
      add_go = add_p_q && (m_slot_stat ? m_same
                : cnt_q < CNT_W'(STATIC_MAX));
      del_go = del_p_q && m_same;
      wkey = key_mem[widx_q];
      wlast = widx_q == IW'(DEPTH - 1);
      take = walk_q == WK_SCAN && val_q[widx_q]
             && (incl_q ? wkey >= base_q : wkey > base_q)
             && (!found_q || wkey < res_key_q);
      busy = walk_q != WK_IDLE || flush_p_q || first_p_q
             || next_p_q || add_p_q || del_p_q;
   end

   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         done_q <= 1'b0;
         fwd_q <= '0;
         drop_q <= 1'b0;
         hit_q <= 1'b0;
      end
      else
      begin
         done_q <= LK_VALID_IN;
         hit_q <= LK_VALID_IN && d_hit;
         drop_q <= LK_VALID_IN && sec_fail;
         if (!LK_VALID_IN || sec_fail)
            fwd_q <= '0;
         else if (d_hit)
            fwd_q <= port_mem[di] & ~src_one;
         else
            fwd_q <= LK_VLAN_PORTS_IN & ~src_one;
      end
   end

   // Key and member storage; management wins over learning
   always_ff @(posedge CORE_CLK_IN)
   begin
      if (learn)
      begin
         key_mem[si] <= skey;
         port_mem[si] <= src_one;
      end
      if (add_go)
      begin
         key_mem[mi] <= mkey;
         port_mem[mi] <= kports_q;
      end
   end

   // Valid, class and activity flags
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         val_q <= '0;
         stat_q <= '0;
         act_q <= '0;
      end
      else
      begin
         if (walk_q == WK_FLUSH && !stat_q[widx_q])
            val_q[widx_q] <= 1'b0;
         if (walk_q == WK_SWEEP && !stat_q[widx_q])
         begin
            if (!act_q[widx_q])
               val_q[widx_q] <= 1'b0;
            act_q[widx_q] <= 1'b0;
         end
         if (learn)
         begin
            val_q[si] <= 1'b1;
            stat_q[si] <= 1'b0;
            act_q[si] <= 1'b1;
         end
         if (add_go)
         begin
            val_q[mi] <= 1'b1;
            stat_q[mi] <= 1'b1;
         end
         if (del_go)
         begin
            val_q[mi] <= 1'b0;
            stat_q[mi] <= 1'b0;
         end
      end
   end

   // Static entry count
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
         cnt_q <= '0;
      else if (add_go && !m_same)
         cnt_q <= cnt_q + CNT_W'(1);
      else if (del_go)
         cnt_q <= cnt_q - CNT_W'(1);
   end

   // One-second tick and aging interval
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         sec_cnt_q <= '0;
         age_cnt_q <= '0;
         sweep_req_q <= 1'b0;
      end
      else
      begin
         if (walk_q == WK_SWEEP)
            sweep_req_q <= 1'b0;
         if (sec_cnt_q == 32'(SEC_CYC - 1))
         begin
            sec_cnt_q <= '0;
            if (ageoff_q)
               age_cnt_q <= '0;
            else if (age_cnt_q >= age_q - AGE_W'(1))
            begin
               age_cnt_q <= '0;
               sweep_req_q <= 1'b1;
            end
            else
               age_cnt_q <= age_cnt_q + AGE_W'(1);
         end
         else
            sec_cnt_q <= sec_cnt_q + 32'd1;
      end
   end

   // Table walker for flush, readout scan and aging sweep
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         walk_q <= WK_IDLE;
         widx_q <= '0;
         base_q <= '0;
         incl_q <= 1'b0;
         found_q <= 1'b0;
         end_q <= 1'b0;
         res_key_q <= '0;
         res_ports_q <= '0;
         res_stat_q <= 1'b0;
      end
      else
      begin
         if (walk_q != WK_IDLE)
            widx_q <= widx_q + IW'(1);
         case (walk_q)
            WK_IDLE:
            begin
               widx_q <= '0;
               if (flush_p_q)
                  walk_q <= WK_FLUSH;
               else if (first_p_q || next_p_q)
               begin
                  walk_q <= WK_SCAN;
                  incl_q <= first_p_q;
                  base_q <= first_p_q ? mkey : res_key_q;
                  found_q <= 1'b0;
                  end_q <= 1'b0;
               end
               else if (sweep_req_q && !ageoff_q && !add_p_q && !del_p_q)
                  walk_q <= WK_SWEEP;
            end
            WK_SCAN:
            begin
               if (take)
               begin
                  found_q <= 1'b1;
                  res_key_q <= wkey;
                  res_ports_q <= port_mem[widx_q];
                  res_stat_q <= stat_q[widx_q];
               end
               if (wlast)
               begin
                  walk_q <= WK_IDLE;
                  end_q <= !(found_q || take);
               end
            end
            WK_SWEEP, WK_FLUSH:
               if (wlast)
                  walk_q <= WK_IDLE;
            default:
               walk_q <= WK_IDLE;
         endcase
      end
   end

   // Bus slave handshakes
   always_comb
   begin
      wr_fire = !awready_q && !wready_q && !bvalid_q;
      wm = wmerge(32'h0000_0000, wdata_q, wstrb_q);
      wm0 = wmerge({8'h00, age_q}, wdata_q, wstrb_q);
      wmode = wmerge(32'(mode_q), wdata_q, wstrb_q);
      wkvid = wmerge(32'(kvid_q), wdata_q, wstrb_q);
      wkmhi = wmerge(32'(kmac_q[47:32]), wdata_q, wstrb_q);
      wkprt = wmerge(32'(kports_q), wdata_q, wstrb_q);
      case (awaddr_q)
         OFS_CTRL, OFS_AGE, OFS_MODE, OFS_KVID, OFS_KMACLO,
         OFS_KMACHI, OFS_KPORTS, OFS_CMD, OFS_STATUS:
            wr_ok = 1'b1;
         default:
            wr_ok = 1'b0;
      endcase
      rd_ok = 1'b1;
      rd_mux = '0;
      case (S_AXI_ARADDR_IN)
         OFS_CTRL:   rd_mux[CTRL_AGEOFF] = ageoff_q;
         OFS_AGE:    rd_mux[AGE_W-1:0] = age_q;
         OFS_MODE:   rd_mux[2*NPORTS-1:0] = mode_q;
         OFS_KVID:   rd_mux[11:0] = kvid_q;
         OFS_KMACLO: rd_mux = kmac_q[31:0];
         OFS_KMACHI: rd_mux[15:0] = kmac_q[47:32];
         OFS_KPORTS: rd_mux[NPORTS-1:0] = kports_q;
         OFS_CMD:    rd_mux = '0;
         OFS_STATUS: rd_mux[14:0] = {cnt_q, 4'h0, err_q, res_stat_q,
                                     end_q, busy};
         OFS_RVID:   rd_mux[11:0] = res_key_q[59:48];
         OFS_RMACLO: rd_mux = res_key_q[31:0];
         OFS_RMACHI: rd_mux[15:0] = res_key_q[47:32];
         OFS_RPORTS: rd_mux[NPORTS-1:0] = res_ports_q;
         default:    rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         if (S_AXI_AWVALID_IN && awready_q)
         begin
            awready_q <= 1'b0;
            awaddr_q <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && wready_q)
         begin
            wready_q <= 1'b0;
            wdata_q <= S_AXI_WDATA_IN;
            wstrb_q <= S_AXI_WSTRB_IN;
         end
         if (wr_fire)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && S_AXI_BREADY_IN)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end
      else if (S_AXI_ARVALID_IN && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && S_AXI_RREADY_IN)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Register writes and command pulses
   always_ff @(posedge CORE_CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         ageoff_q <= 1'b0;
         age_q <= AGE_RST;
         mode_q <= '0;
         kvid_q <= '0;
         kmac_q <= '0;
         kports_q <= '0;
         err_q <= 1'b0;
         {flush_p_q, first_p_q, next_p_q} <= 3'b000;
         {add_p_q, del_p_q} <= 2'b00;
      end
      else
      begin
         {flush_p_q, first_p_q, next_p_q} <= 3'b000;
         {add_p_q, del_p_q} <= 2'b00;
         if (wr_fire)
            case (awaddr_q)
               OFS_CTRL:
               begin
                  if (wstrb_q[0])
                     ageoff_q <= wdata_q[CTRL_AGEOFF];
                  if (!busy)
                  begin
                     flush_p_q <= wm[CTRL_FLUSH];
                     first_p_q <= wm[CTRL_FIRST] && !wm[CTRL_FLUSH];
                     next_p_q <= wm[CTRL_NEXT] && !wm[CTRL_FIRST]
                                 && !wm[CTRL_FLUSH];
                  end
               end
               OFS_AGE:
                  if (wm0 >= AGE_MIN && wm0 <= AGE_MAX)
                     age_q <= wm0[AGE_W-1:0];
               OFS_MODE:
                  for (int p = 0; p < NPORTS; p++)
                     if (!MODE_LOCK_IN[p])
                        mode_q[2*p +: 2] <= wmode[2*p +: 2];
               OFS_KVID:
                  kvid_q <= wkvid[11:0];
               OFS_KMACLO:
                  kmac_q[31:0] <= wmerge(kmac_q[31:0], wdata_q, wstrb_q);
               OFS_KMACHI:
                  kmac_q[47:32] <= wkmhi[15:0];
               OFS_KPORTS:
                  kports_q <= wkprt[NPORTS-1:0];
               OFS_CMD:
                  if (!busy)
                  begin
                     add_p_q <= wm[CMD_ADD];
                     del_p_q <= wm[CMD_DEL] && !wm[CMD_ADD];
                  end
               OFS_STATUS:
                  if (wm[ST_ERR])
                     err_q <= 1'b0;
               default:
                  err_q <= err_q;
            endcase
         // Refusals raise the sticky error; a new one beats the clear
         if ((wr_fire && busy && ((awaddr_q == OFS_CMD && |wm[1:0])
              || (awaddr_q == OFS_CTRL && |wm[3:1])))
             || (wr_fire && awaddr_q == OFS_AGE
                 && !(wm0 >= AGE_MIN && wm0 <= AGE_MAX))
             || (add_p_q && !add_go) || (del_p_q && !del_go))
            err_q <= 1'b1;
      end
   end

   assign S_AXI_AWREADY_OUT = awready_q;
   assign S_AXI_WREADY_OUT  = wready_q;
   assign S_AXI_BVALID_OUT  = bvalid_q;
   assign S_AXI_BRESP_OUT   = bresp_q;
   assign S_AXI_ARREADY_OUT = arready_q;
   assign S_AXI_RVALID_OUT  = rvalid_q;
   assign S_AXI_RDATA_OUT   = rdata_q;
   assign S_AXI_RRESP_OUT   = rresp_q;
   assign LK_DONE_OUT       = done_q;
   assign LK_FWD_PORTS_OUT  = fwd_q;
   assign LK_DROP_OUT       = drop_q;
   assign LK_HIT_OUT        = hit_q;
endmodule

/* tb/mact_chk_assertions.sv */
// Checker for lookup answers and register bus responses
`timescale 1ns/1ps
module mact_chk #(
   parameter int unsigned NPORTS = 11
)(
   input wire logic CORE_CLK_IN, RESET_IN, LK_VALID_IN, LK_DONE_OUT,
   input wire logic LK_HIT_OUT, LK_DROP_OUT, S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN, S_AXI_RVALID_OUT, S_AXI_RREADY_IN,
   input wire logic [$clog2(NPORTS)-1:0] LK_SRC_PORT_IN,
   input wire logic [NPORTS-1:0] LK_VLAN_PORTS_IN, LK_FWD_PORTS_OUT
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (RESET_IN);
   AST_DONE: assert property (LK_VALID_IN |=> LK_DONE_OUT)
      else $error("lookup answer missing");
   AST_IDLE: assert property (!LK_VALID_IN |=> !LK_DONE_OUT
      && LK_FWD_PORTS_OUT == '0) else $error("answer without request");
   AST_FLAGS: assert property (LK_HIT_OUT || LK_DROP_OUT |->
      LK_DONE_OUT) else $error("flag outside answer");
   AST_NOSRC: assert property (LK_DONE_OUT |->
      !LK_FWD_PORTS_OUT[$past(LK_SRC_PORT_IN)]) else $error("sent back");
   AST_MISS: assert property (LK_DONE_OUT && !LK_HIT_OUT &&
      !LK_DROP_OUT |-> LK_FWD_PORTS_OUT == ($past(LK_VLAN_PORTS_IN)
      & ~(NPORTS'(1) << $past(LK_SRC_PORT_IN)))) else $error("bad flood");
   AST_DROP: assert property (LK_DROP_OUT |->
      LK_FWD_PORTS_OUT == '0) else $error("dropped frame forwarded");
   AST_BDONE: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN
      |=> !S_AXI_BVALID_OUT) else $error("write answer stuck");
   AST_RDONE: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN
      |=> !S_AXI_RVALID_OUT) else $error("read answer stuck");
   COV_HIT: cover property (LK_HIT_OUT);
   COV_DROP: cover property (LK_DROP_OUT);
   COV_MISS: cover property (LK_DONE_OUT && !LK_HIT_OUT);
endmodule
bind mact_table mact_chk #(.NPORTS(NPORTS)) i_chk (.*);

/* tb/mact_pipe_model.sv */
// Frame pipeline model issuing lookup requests
`timescale 1ns/1ps
module mact_pipe_model (
   input  wire logic        clk_in,
   output logic             valid_out = 1'b0,
   output logic [47:0]      dst_out = '0,
   output logic [47:0]      src_out = '0,
   output logic [3:0]       port_out = '0
);
   // One-cycle request; fields scrambled once released
   task automatic send(input logic [47:0] s, d, input logic [3:0] p);
      @(posedge clk_in);
      valid_out <= 1'b1;
      src_out <= s;
      dst_out <= d;
      port_out <= p;
      @(posedge clk_in);
      valid_out <= 1'b0;
      {src_out, dst_out, port_out} <= ~{s, d, p};
   endtask
endmodule

/* tb/mac_address_table_learning_test.sv */
// Self-checking bench for the forwarding table
`timescale 1ns/1ps
module mac_address_table_learning_test;
   import mact_pkg::*;
   logic        clk = 1'b0, rst = 1'b1;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, done, hit, drop;
   logic        valid;
   logic [1:0]  rresp, bresp, bseen;
   logic [10:0] lock = '0, fwd;
   logic [47:0] dst, src;
   logic [3:0]  port;
   int          errors = 0, checks = 0;
   mact_table #(.DEPTH(64), .SEC_CYC(20)) i_dut (
      .CORE_CLK_IN(clk), .RESET_IN(rst), .S_AXI_AWADDR_IN(awaddr),
      .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
      .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
      .LK_VALID_IN(valid), .LK_VID_IN(12'h001), .LK_DEST_HW_ADDR_IN(dst),
      .LK_SRC_HW_ADDR_IN(src), .LK_SRC_PORT_IN(port),
      .LK_VLAN_PORTS_IN(11'h7FF), .LK_DONE_OUT(done), .LK_FWD_PORTS_OUT(fwd),
      .LK_DROP_OUT(drop), .LK_HIT_OUT(hit), .MODE_LOCK_IN(lock));
   mact_pipe_model i_pipe (.clk_in(clk), .valid_out(valid), .dst_out(dst),
      .src_out(src), .port_out(port));
   initial
   begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [47:0] e, g);
      checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
      bseen = bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk("register", e, d);
   endtask
   task automatic idle;
      logic [31:0] d;
      logic [1:0]  r;
      do
         rd(OFS_STATUS, d, r);
      while (d[0]);
   endtask
   task automatic lk(input logic [47:0] s, d, input logic [3:0] p,
                     input logic [10:0] f, input logic h, x);
      i_pipe.send(s, d, p);
      #1;
      chk("lookup", {1'b1, f, h, x}, {done, fwd, hit, drop});
   endtask
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rdc(OFS_AGE, 32'h0000_012C);
      rdc(OFS_CTRL, 32'h0000_0000);
      rd(8'hFC, d, r);
      chk("resp", RESP_SLVERR, r);
      wr(8'hFC, 32'h0000_0000);
      chk("bresp", RESP_SLVERR, bseen);
   endtask
   task automatic t_learn;
      lk(48'h11, 48'h12, 2, 11'h7FB, 0, 0);
      lk(48'h12, 48'h11, 5, 11'h004, 1, 0);
      lk(48'h11, 48'h12, 2, 11'h020, 1, 0);
   endtask
   task automatic t_modes;
      wr(OFS_MODE, 32'h0000_2040);
      lk(48'h13, 48'h11, 3, 11'h004, 1, 0);
      lk(48'h11, 48'h13, 2, 11'h7FB, 0, 0);
      wr(OFS_KVID, 32'h0000_0001);
      wr(OFS_KMACLO, 32'h0000_0014);
      wr(OFS_KPORTS, 32'h0000_0010);
      wr(OFS_CMD, 32'h0000_0001);
      idle;
      lk(48'h15, 48'h99, 6, 11'h000, 0, 1);
      lk(48'h14, 48'h14, 6, 11'h010, 1, 0);
      lk(48'h11, 48'h15, 2, 11'h7FB, 0, 0);
      @(posedge clk) lock <= 11'h001;
      wr(OFS_MODE, 32'h0000_2041);
      chk("bresp", RESP_OKAY, bseen);
      rdc(OFS_MODE, 32'h0000_2040);
   endtask
   task automatic t_age;
      logic [31:0] d;
      logic [1:0]  r;
      wr(OFS_AGE, 32'h0000_0009);
      rdc(OFS_AGE, 32'h0000_012C);
      rd(OFS_STATUS, d, r);
      chk("err", 1'b1, d[3]);
      wr(OFS_AGE, 32'h0000_000A);
      wr(OFS_CTRL, 32'h0000_0001);
      lk(48'h17, 48'h11, 1, 11'h004, 1, 0);
      repeat (600) @(posedge clk);
      lk(48'h11, 48'h17, 2, 11'h002, 1, 0);
      wr(OFS_CTRL, 32'h0000_0000);
      lk(48'h16, 48'h11, 1, 11'h004, 1, 0);
      repeat (600) @(posedge clk);
      lk(48'h11, 48'h16, 2, 11'h7FB, 0, 0);
   endtask
   task automatic t_read;
      logic [31:0] d;
      logic [1:0]  r;
      // Aging off so no sweep makes the walker refuse commands
      wr(OFS_CTRL, 32'h0000_0001);
      idle;
      wr(OFS_CTRL, 32'h0000_0003);
      idle;
      wr(OFS_KMACLO, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0005);
      idle;
      rdc(OFS_RVID, 32'h0000_0001);
      rdc(OFS_RMACLO, 32'h0000_0014);
      rdc(OFS_RPORTS, 32'h0000_0010);
      rd(OFS_STATUS, d, r);
      chk("kind", 2'b10, d[2:1]);
      wr(OFS_CTRL, 32'h0000_0009);
      idle;
      rd(OFS_STATUS, d, r);
      chk("end", 1'b1, d[1]);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      summarize;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_learn;
      t_modes;
      t_age;
      t_read;
      summarize;
   end
endmodule
